/* File: verilog/hwcur_top.sv */
// Hardware cursor: position registers, cursor signal, line counter, pixel shifter.
`timescale 1ns/10ps
module hwcur_top #(
  parameter int unsigned ADDR_W = 15
) (
  // Clock and reset
  input  wire logic                           core_clk_in,
  input  wire logic                           nrst_in,
  // Host word writes into the video address space
  input  wire logic                           host_wr_in,
  input  wire logic [ADDR_W-1:0]              host_addr_in,
  input  wire logic [hwcur_pkg::CUR_PIX-1:0]  host_data_in,
  // Timing controller cursor register writes
  input  wire logic                           start_wr_in,
  input  wire logic [hwcur_pkg::START_W-1:0]  start_data_in,
  input  wire logic                           end_wr_in,
  input  wire logic [hwcur_pkg::SCAN_W-1:0]   end_data_in,
  input  wire logic                           row_wr_in,
  input  wire logic [hwcur_pkg::ROW_W-1:0]    row_data_in,
  input  wire logic                           xpos_wr_in,
  input  wire logic [hwcur_pkg::X_W-1:0]      xpos_data_in,
  // Raster position, same clock
  input  wire logic                           line_start_in,
  input  wire logic                           frame_start_in,
  input  wire logic [hwcur_pkg::ROW_W-1:0]    char_row_in,
  input  wire logic [hwcur_pkg::SCAN_W-1:0]   row_scan_in,
  input  wire logic [hwcur_pkg::X_W-1:0]      beam_x_in,
  // Cursor outputs and status
  output      logic                           cursor_sig_out,
  output      logic                           cursor_active_out,
  output      logic [hwcur_pkg::RAM_AW-1:0]   cursor_line_out,
  output      logic                           cursor_pix_out,
  output      logic [hwcur_pkg::SCAN_W-1:0]   cursor_end_out
);
  import hwcur_pkg::*;

  //----------------------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------------------
  logic [START_W-1:0]    start_q;
  logic [SCAN_W-1:0]     end_q;
  logic [ROW_W-1:0]      row_q;
  logic [X_W-1:0]        xpos_q;
  logic [FRAME_W-1:0]    frame_q;
  hwcur_state_e          state_q;
  logic [LINE_CNT_W-1:0] lines_q;
  logic                  ram_hit;
  logic                  cur_hit;
  logic                  blink_on;
  logic [X_W-1:0]        x_off;
  logic                  in_span;
  logic                  run_idle;
  logic                  line_last;

  //----------------------------------------------------------------------------
  // Cursor RAM
  //----------------------------------------------------------------------------
  // The RAM sits behind an interface so its write and read sides stay grouped
  hwcur_ram_if ram_bus ();

  // Read port follows the line counter, so a row word is ready a cycle after
  // the counter steps and well before the beam reaches the cursor
  hwcur_ram u_ram (
    .core_clk_in (core_clk_in),
    .ram         (ram_bus.mem)
  );

  // Only the top 16 words of the space land in the cursor RAM
  assign ram_hit          = &host_addr_in[ADDR_W-1:RAM_AW];
  assign ram_bus.wr_en    = host_wr_in & ram_hit;
  assign ram_bus.wr_addr  = host_addr_in[RAM_AW-1:0];
  assign ram_bus.wr_data  = host_data_in;
  assign ram_bus.rd_addr  = lines_q[RAM_AW-1:0];

  // Start register: scan line, blink rate, enable
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      start_q <= START_RST;
    end else if (start_wr_in) begin
      start_q <= start_data_in;
    end
  end

  // End scan register, kept for software readback
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      end_q <= SCAN_RST;
    end else if (end_wr_in) begin
      end_q <= end_data_in;
    end
  end

  // Character row of the cursor
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      row_q <= ROW_RST;
    end else if (row_wr_in) begin
      row_q <= row_data_in;
    end
  end

  // Horizontal position; zero is the left edge, unsigned so never below it.
  // No upper clamp: software keeps X and Y 16 short of the last pixel and line,
  // otherwise part of the cursor falls off the edge of the raster.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      xpos_q <= X_RST;
    end else if (xpos_wr_in) begin
      xpos_q <= xpos_data_in;
    end
  end

  //----------------------------------------------------------------------------
  // Cursor signal and blink
  //----------------------------------------------------------------------------
  // Frame counter drives the blink phase
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      frame_q <= '0;
    end else if (frame_start_in) begin
      frame_q <= frame_q + 1'b1;
    end
  end

  assign blink_on = start_q[BLINK_BIT] ? frame_q[BLINK_SLOW] : frame_q[BLINK_FAST];

  // Row and scan match at line start; Y of zero means row 0, scan 0
  assign cur_hit = line_start_in & start_q[ENA_BIT] & blink_on
                 & (char_row_in == row_q)
                 & (row_scan_in == start_q[START_LSB +: SCAN_W]);

  // Counter is free to take a new start only when it is idle
  assign run_idle = (state_q == HWCUR_IDLE);

  // One-cycle cursor pulse as the timing controller would give it. A match that
  // lands during a run is refused here too, so every pulse starts exactly one
  // pass and the pulse count always equals the run count.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cursor_sig_out <= 1'b0;
    end else begin
      cursor_sig_out <= cur_hit & run_idle;
    end
  end

  //----------------------------------------------------------------------------
  // 16-line counter
  //----------------------------------------------------------------------------
  // Last counted line; the run ends on the line start that follows it
  assign line_last = (lines_q == LINE_CNT_W'(CUR_LINES - 1));

  // Counter runs through all 16 lines once started; a new hit mid-run is ignored
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= HWCUR_IDLE;
      lines_q <= '0;
    end else begin
      unique case (state_q)
        HWCUR_IDLE: begin
          if (cur_hit) begin
            state_q <= HWCUR_RUN;
            lines_q <= '0;
          end
        end
        HWCUR_RUN: begin
          if (line_start_in) begin
            if (line_last) begin
              state_q <= HWCUR_IDLE;
              lines_q <= '0;
            end else begin
              lines_q <= lines_q + 1'b1;
            end
          end
        end
        default: begin
          state_q <= HWCUR_IDLE;
          lines_q <= '0;
        end
      endcase
    end
  end

  // Run status, one cycle behind the counter so it lines up with the RAM word
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cursor_active_out <= 1'b0;
    end else begin
      cursor_active_out <= (state_q == HWCUR_RUN);
    end
  end

  // Counter value for status, same delay as the run flag
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cursor_line_out <= '0;
    end else begin
      cursor_line_out <= lines_q[RAM_AW-1:0];
    end
  end

  // End scan echo only; it does not shorten the 16-line run
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cursor_end_out <= SCAN_RST;
    end else begin
      cursor_end_out <= end_q;
    end
  end

  //----------------------------------------------------------------------------
  // Pixel shifter
  //----------------------------------------------------------------------------
  // Offset wraps when left of X, so one compare covers both edges
  assign x_off   = beam_x_in - xpos_q;
  assign in_span = (x_off < X_W'(CUR_PIX));

  // MSB of the row word is the leftmost pixel
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cursor_pix_out <= 1'b0;
    end else begin
      cursor_pix_out <= (state_q == HWCUR_RUN) & in_span
                      & ram_bus.rd_data[RAM_AW'(CUR_PIX - 1) - x_off[RAM_AW-1:0]];
    end
  end
endmodule // hwcur_top

/* File: verilog/hwcur_pkg.sv */
// Constants and field layouts for the hardware cursor block.
//------------------------------------------------------------------------------
// Functional notes
// - The cursor image lives in its own cursor RAM at the top 16 words (32 bytes) of the address space.
// - The cursor start register also holds a cursor enable bit and a blink rate bit.
// - With the registers loaded the timing controller raises a cursor signal that starts a 16-line counter addressing the RAM.
// - The lowest X and Y positions are both zero.
//------------------------------------------------------------------------------
package hwcur_pkg;
  // Cursor geometry
  localparam int unsigned CUR_LINES  = 16;
  localparam int unsigned CUR_PIX    = 16;
  localparam int unsigned RAM_AW     = 4;
  localparam int unsigned LINE_CNT_W = 5;
  // Position field widths
  localparam int unsigned SCAN_W     = 4;
  localparam int unsigned ROW_W      = 6;
  localparam int unsigned X_W        = 11;
  // Cursor start register layout
  localparam int unsigned START_W    = 7;
  localparam int unsigned START_LSB  = 0;
  localparam int unsigned BLINK_BIT  = 5;
  localparam int unsigned ENA_BIT    = 6;
  // Blink phase taps on the frame counter: fast and slow
  localparam int unsigned FRAME_W    = 6;
  localparam int unsigned BLINK_FAST = 4;
  localparam int unsigned BLINK_SLOW = 5;
  // Reset values
  localparam logic [START_W-1:0] START_RST = 7'h00;
  localparam logic [X_W-1:0]     X_RST     = 11'h000;
  localparam logic [ROW_W-1:0]   ROW_RST   = 6'h00;
  localparam logic [SCAN_W-1:0]  SCAN_RST  = 4'h0;

  // Line counter states
  typedef enum logic [1:0] {
    HWCUR_IDLE = 2'b01,
    HWCUR_RUN  = 2'b10
  } hwcur_state_e;
endpackage

/* File: verilog/hwcur_ram_if.sv */
// Interface between the cursor controller and its cursor RAM.
`timescale 1ns/10ps
interface hwcur_ram_if;
  import hwcur_pkg::*;
  logic                wr_en;
  logic [RAM_AW-1:0]   wr_addr;
  logic [CUR_PIX-1:0]  wr_data;
  logic [RAM_AW-1:0]   rd_addr;
  logic [CUR_PIX-1:0]  rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

/* File: verilog/hwcur_ram.sv */
// Cursor image RAM: 16 rows of 16 pixels, synchronous read.
`timescale 1ns/10ps
module hwcur_ram (
  // Clock
  input  wire logic core_clk_in,
  // RAM port
  hwcur_ram_if.mem  ram
);
  import hwcur_pkg::*;

  logic [CUR_PIX-1:0] mem_q [CUR_LINES];

  // Image store, one word per cursor line
  always_ff @(posedge core_clk_in) begin
    if (ram.wr_en) begin
      mem_q[ram.wr_addr] <= ram.wr_data;
    end
  end

  // Registered read; address is set at the line start, early in the line that uses it
  always_ff @(posedge core_clk_in) begin
    ram.rd_data <= mem_q[ram.rd_addr];
  end
endmodule // hwcur_ram

/* File: verification/hwcur_checker.sv */
// Port-level assertions for the hardware cursor block.
`timescale 1ns/10ps
module hwcur_checker (
  // Clock, reset, register writes
  input wire logic        core_clk_in, nrst_in, start_wr_in, row_wr_in, xpos_wr_in,
  input wire logic [6:0]  start_data_in,
  input wire logic [5:0]  row_data_in, char_row_in,
  input wire logic [10:0] xpos_data_in, beam_x_in,
  // Raster and cursor outputs
  input wire logic        line_start_in, cursor_sig_out, cursor_active_out, cursor_pix_out,
  input wire logic [3:0]  row_scan_in, cursor_line_out
);
  logic [6:0]  st_q;
  logic [5:0]  rw_q;
  logic [10:0] x_q;
  logic        hit_w;
  // Shadow registers, so each output can be tied to its cause
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= 7'h00;
      rw_q <= 6'h00;
      x_q  <= 11'h000;
    end else begin
      if (start_wr_in) st_q <= start_data_in;
      if (row_wr_in) rw_q <= row_data_in;
      if (xpos_wr_in) x_q <= xpos_data_in;
    end
  end
  // Blink phase is internal, so a hit is only a necessary cause
  assign hit_w = line_start_in && st_q[6] && char_row_in == rw_q && row_scan_in == st_q[3:0];
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_first;
    cursor_active_out && cursor_line_out == 4'h0;
  endsequence
  sig_pulse_a: assert property (cursor_sig_out |=> !cursor_sig_out)
    else $error("cursor signal wider than one cycle");
  sig_cause_a: assert property (cursor_sig_out |-> $past(hit_w))
    else $error("cursor signal without a matching line");
  run_first_a: assert property (cursor_sig_out |=> s_first)
    else $error("run did not begin at line zero");
  hit_refused_a: assert property (cursor_sig_out |-> !cursor_active_out)
    else $error("cursor signal during a run");
  line_step_a: assert property (cursor_active_out && $past(cursor_active_out) &&
    $past(line_start_in, 2) |-> cursor_line_out == $past(cursor_line_out) + 4'h1)
    else $error("line counter did not step");
  line_hold_a: assert property (cursor_active_out && $past(cursor_active_out) &&
    !$past(line_start_in, 2) |-> $stable(cursor_line_out))
    else $error("line counter moved without a line start");
  run_end_a: assert property ($fell(cursor_active_out) |-> $past(cursor_line_out) == 4'hf)
    else $error("run length not sixteen lines");
  pix_window_a: assert property (cursor_pix_out |-> cursor_active_out &&
    11'($past(beam_x_in) - $past(x_q)) < 11'd16)
    else $error("cursor pixel outside its window");
  reset_quiet_a: assert property (!$past(nrst_in) |-> !cursor_sig_out && !cursor_active_out)
    else $error("outputs busy after reset");
endmodule // hwcur_checker
bind hwcur_top hwcur_checker u_hwcur_checker (.core_clk_in, .nrst_in, .start_wr_in,
  .row_wr_in, .xpos_wr_in, .start_data_in, .row_data_in, .char_row_in, .xpos_data_in,
  .beam_x_in, .line_start_in, .cursor_sig_out, .cursor_active_out, .cursor_pix_out,
  .row_scan_in, .cursor_line_out);

/* File: verification/hwcur_tb_top.sv */
// Self-checking bench for the hardware cursor block.
`timescale 1ns/10ps
module hwcur_tb_top;
  logic clk = 0, rst_n = 0, hwr = 0, swr = 0, ewr = 0, rwr = 0, xwr = 0, ls = 0, fs = 0;
  logic [14:0] addr = 0;
  logic [15:0] data = 0, lf = 16'd92;
  logic [6:0]  sd = 0;
  logic [3:0]  ed = 0, scan = 0, ln_o, end_o;
  logic [5:0]  rd = 0, row = 0;
  logic [10:0] xd = 0, bx = 0;
  logic        sig, act, pix;
  logic [15:0] img [16];
  int mismatches = 0, checks = 0, cyc = 0, ln = 0, sq[$], pq[$];
  bit run = 0, pv[$];
  initial forever #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  hwcur_top u_hwcur_top (.core_clk_in(clk), .nrst_in(rst_n), .host_wr_in(hwr),
    .host_addr_in(addr), .host_data_in(data), .start_wr_in(swr), .start_data_in(sd),
    .end_wr_in(ewr), .end_data_in(ed), .row_wr_in(rwr), .row_data_in(rd), .xpos_wr_in(xwr),
    .xpos_data_in(xd), .line_start_in(ls), .frame_start_in(fs), .char_row_in(row),
    .row_scan_in(scan), .beam_x_in(bx), .cursor_sig_out(sig), .cursor_active_out(act),
    .cursor_line_out(ln_o), .cursor_pix_out(pix), .cursor_end_out(end_o));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic tick(input int n = 1);
    repeat (n) begin @(posedge clk); #1; end
  endtask
  task automatic cmp(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobe for one cycle; the idle cycle keeps strobes from re-rising in one step
  task automatic pulse(ref logic s);
    s = 1; tick(); s = 0; tick();
  endtask
  // One scan line: note the expected cursor signal, then sweep the beam past X
  task automatic line(input logic [5:0] r, input logic [3:0] s, input bit hit);
    row = r; scan = s; ls = 1;
    if (run) begin if (ln == 15) run = 0; else ln++; end
    else if (hit) begin run = 1; ln = 0; sq.push_back(cyc + 1); end
    tick(); ls = 0; tick(2);
    cmp(16'({act, ln_o}), 16'({run, 4'(run ? ln : 0)}));
    for (int k = -2; k < 18; k++) begin
      bx = xd + 11'(k);
      pq.push_back(cyc); pv.push_back(run && k >= 0 && k < 16 && img[ln][15-k]);
      tick();
    end
  endtask
  // Monitor: pop the oldest note whenever a result is due
  always @(negedge clk) begin
    if (pq.size() > 0 && pq[0] < cyc) begin
      cmp(pix, pv[0]);
      void'(pq.pop_front()); void'(pv.pop_front());
    end
    if (sig === 1'b1) cmp(sq.size() ? sq.pop_front() : 0, cyc);
  end
  task automatic print_verdict();
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin #200000; mismatches++; print_verdict(); end
  initial begin
    tick(8); rst_n = 1; tick();
    for (int i = 0; i < 16; i++) begin
      lf = nxt(lf); img[i] = lf; addr = {11'h7ff, 4'(i)}; data = lf; pulse(hwr);
    end
    addr = 15'h000f; data = ~img[15]; pulse(hwr);
    sd = 7'h43; pulse(swr); ed = 4'h5; pulse(ewr); rd = 6'h02; pulse(rwr);
    cmp(16'(end_o), 16'h5);
    lf = nxt(lf); xd = {1'b0, lf[9:0]}; pulse(xwr);
    line(2, 3, 0); // Blink phase still dark
    repeat (16) pulse(fs);
    for (int s = 0; s < 16; s++) line(2, 4'(s), s == 3);
    for (int s = 0; s < 4; s++) line(2, 4'(s), s == 3);
    rd = 6'h03; pulse(rwr);
    xd = 0; pulse(xwr);
    for (int s = 4; s < 36; s++) line(3, 4'(s), s == 19);
    sd = 7'h03; pulse(swr); line(3, 3, 0);
    sd = 7'h63; pulse(swr); line(3, 3, 0);
    repeat (16) pulse(fs);
    line(3, 3, 1);
    tick(4); cmp(16'(sq.size()), 0);
    print_verdict();
  end
endmodule // hwcur_tb_top
